//--- core/adc_host_register_port.sv
// Host register port of the converter: pin decode, registers, result path.
// Assumes the analog core delivers one raw two's complement code per
// sample strobe and that clk is the converter sample clock.
`timescale 1ns/1ns
`default_nettype none

module adc_host_register_port #(
  parameter int DATA_W      = adc_regs_pkg::DATA_W,
  parameter int PIPE_STAGES = adc_regs_pkg::PIPE_STAGES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              chipSelectN,
  input  wire logic              writeStrobeN,
  input  wire logic              outputEnableN,
  input  wire logic              regSelectHi,
  input  wire logic              regSelectLo,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataOutEnN,
  input  wire logic [DATA_W-1:0] rawSample,
  input  wire logic              rawValid,
  input  wire logic              rawOverRange,
  output logic                   sampleReady,
  output logic                   rangeExceeded,
  output logic                   sleepRequest,
  output logic                   extRefSelect,
  output logic      [2:0]        gainCode,
  output logic      [2:0]        stimulusSelect
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int PW = adc_regs_pkg::PINS_W;
  localparam int SW = adc_regs_pkg::SAMPLE_W;

  logic [PW-1:0]              pinsRaw;
  logic [PW-1:0]              syncA_q;
  logic [PW-1:0]              syncB_q;
  logic [PW-1:0]              syncC_q;
  logic [PW-1:0]              pinsFilt_q;
  logic [PW-1:0]              pinsFilt_d;
  adc_regs_pkg::host_pins_s   pins;
  logic                       strobePrev_q;
  logic                       strobePrev_d;
  logic                       writeTaken;
  logic [1:0]                 addr;

  logic [DATA_W-1:0]          gain_q;
  logic [DATA_W-1:0]          gain_d;
  logic [DATA_W-1:0]          offset_q;
  logic [DATA_W-1:0]          offset_d;
  logic [DATA_W-1:0]          setup_q;
  logic [DATA_W-1:0]          setup_d;

  adc_regs_pkg::sample_s      pipe_q [PIPE_STAGES];
  adc_regs_pkg::sample_s      pipe_d [PIPE_STAGES];
  logic [PIPE_STAGES-1:0]     pipeValid_q;
  logic [PIPE_STAGES-1:0]     pipeValid_d;
  adc_regs_pkg::sample_s      entry;
  logic                       stall;
  logic signed [DATA_W:0]     sum;
  logic signed [DATA_W:0]     sat;

  logic                       bufInReady;
  logic                       bufOutValid;
  logic                       bufOutReady;
  logic [SW-1:0]              bufOutData;
  adc_regs_pkg::sample_s      result_q;
  adc_regs_pkg::sample_s      result_d;
  logic [DATA_W-1:0]          dataOut_q;
  logic [DATA_W-1:0]          dataOut_d;
  logic                       dataOutEnN_q;
  logic                       dataOutEnN_d;
  logic                       over_q;
  logic                       over_d;

  // ----------------------------------------------------------------
  // Pin synchroniser: three flops, a change counts once B and C agree
  // ----------------------------------------------------------------
  assign pinsRaw = {chipSelectN, writeStrobeN, outputEnableN,
                    regSelectHi, regSelectLo, dataIn};

  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_q <= adc_regs_pkg::PINS_IDLE;
      syncB_q <= adc_regs_pkg::PINS_IDLE;
      syncC_q <= adc_regs_pkg::PINS_IDLE;
    end else begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  always_comb begin
    pinsFilt_d = pinsFilt_q;
    for (int i = 0; i < PW; i++) begin
      if (syncB_q[i] == syncC_q[i]) begin
        pinsFilt_d[i] = syncC_q[i];
      end
    end
  end

  assign pins = adc_regs_pkg::host_pins_s'(pinsFilt_q);
  assign addr = {pins.regSelectHi, pins.regSelectLo};

  // ----------------------------------------------------------------
  // Write detection: strobe rising while chip select is low
  // ----------------------------------------------------------------
  assign strobePrev_d = pins.writeStrobeN;
  assign writeTaken   = pins.writeStrobeN && !strobePrev_q && !pins.chipSelectN; // [RQ18]

  always_ff @(posedge clk) begin
    if (reset) begin
      pinsFilt_q   <= adc_regs_pkg::PINS_IDLE;
      strobePrev_q <= 1'b1;
    end else begin
      pinsFilt_q   <= pinsFilt_d;
      strobePrev_q <= strobePrev_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    gain_d   = gain_q;
    offset_d = offset_q;
    setup_d  = setup_q;
    if (writeTaken) begin
      case (addr) // [RQ1]
        adc_regs_pkg::ADDR_GAIN: begin
          gain_d = pins.data; // [RQ6]
        end
        adc_regs_pkg::ADDR_OFFSET: begin
          offset_d = pins.data; // [RQ7]
        end
        adc_regs_pkg::ADDR_SETUP: begin
          setup_d = pins.data; // [RQ13]
        end
        default: begin
          gain_d = gain_q; // [RQ18]
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gain_q   <= adc_regs_pkg::GAIN_RESET; // [RQ2]
      offset_q <= adc_regs_pkg::OFFSET_RESET; // [RQ2]
      setup_q  <= adc_regs_pkg::SETUP_RESET; // [RQ2]
    end else begin
      gain_q   <= gain_d;
      offset_q <= offset_d;
      setup_q  <= setup_d;
    end
  end

  // ----------------------------------------------------------------
  // Analog core settings
  // ----------------------------------------------------------------
  assign sleepRequest   = setup_q[adc_regs_pkg::SETUP_SLEEP_BIT]; // [RQ10]
  assign extRefSelect   = setup_q[adc_regs_pkg::SETUP_EXTREF_BIT]; // [RQ11]
  assign gainCode       = gain_q[adc_regs_pkg::GAIN_W-1:0]; // [RQ6]
  assign stimulusSelect = setup_q[adc_regs_pkg::SETUP_STIM_LSB +: adc_regs_pkg::STIM_W]; // [RQ12]

  // ----------------------------------------------------------------
  // Offset correction, saturation and output coding
  // ----------------------------------------------------------------
  always_comb begin
    sum = {rawSample[DATA_W-1], rawSample};
    if (!setup_q[adc_regs_pkg::SETUP_OFFDIS_BIT]) begin // [RQ9]
      sum = sum + {{(DATA_W + 1 - adc_regs_pkg::OFFS_W)
                    {offset_q[adc_regs_pkg::OFFS_W-1]}},
                   offset_q[adc_regs_pkg::OFFS_W-1:0]}; // [RQ8]
    end
    if (sum > adc_regs_pkg::CODE_MAX) begin
      sat = adc_regs_pkg::CODE_MAX; // [RQ4]
    end else if (sum < adc_regs_pkg::CODE_MIN) begin
      sat = adc_regs_pkg::CODE_MIN; // [RQ4]
    end else begin
      sat = sum;
    end
    entry.code = sat[DATA_W-1:0];
    if (!setup_q[adc_regs_pkg::SETUP_TWOS_BIT]) begin // [RQ5]
      entry.code[DATA_W-1] = ~sat[DATA_W-1]; // [RQ4]
    end
    entry.over = rawOverRange; // [RQ17]
  end

  // ----------------------------------------------------------------
  // Latency pipeline, held when the buffer refuses a word
  // ----------------------------------------------------------------
  assign stall       = pipeValid_q[PIPE_STAGES-1] && !bufInReady;
  assign sampleReady = !stall;

  always_comb begin
    pipe_d      = pipe_q;
    pipeValid_d = pipeValid_q;
    if (!stall) begin
      pipe_d[0]      = entry; // [RQ15]
      pipeValid_d[0] = rawValid && !sleepRequest;
      for (int i = 1; i < PIPE_STAGES; i++) begin
        pipe_d[i]      = pipe_q[i-1]; // [RQ15]
        pipeValid_d[i] = pipeValid_q[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe_q[i] <= '0;
      end
      pipeValid_q <= '0;
    end else begin
      pipe_q      <= pipe_d;
      pipeValid_q <= pipeValid_d;
    end
  end

  two_entry_buffer #(
    .WIDTH (SW),
    .DEPTH (2)
  ) resultBuffer (
    .clk      (clk),
    .reset    (reset),
    .inValid  (pipeValid_q[PIPE_STAGES-1]),
    .inReady  (bufInReady),
    .inData   (pipe_q[PIPE_STAGES-1]),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // ----------------------------------------------------------------
  // Result register, frozen while the host reads it
  // ----------------------------------------------------------------
  assign bufOutReady = !(!pins.chipSelectN && !pins.outputEnableN
                         && addr == adc_regs_pkg::ADDR_RESULT);

  always_comb begin
    result_d = result_q;
    if (bufOutValid && bufOutReady) begin
      result_d = adc_regs_pkg::sample_s'(bufOutData);
    end
    over_d = result_q.over; // [RQ17]
  end

  // ----------------------------------------------------------------
  // Read multiplexer and pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    case (addr) // [RQ1]
      adc_regs_pkg::ADDR_RESULT: begin
        dataOut_d = result_q.code; // [RQ3]
      end
      adc_regs_pkg::ADDR_GAIN: begin
        dataOut_d = gain_q;
      end
      adc_regs_pkg::ADDR_OFFSET: begin
        dataOut_d = offset_q;
      end
      adc_regs_pkg::ADDR_SETUP: begin
        dataOut_d = setup_q; // [RQ14]
      end
      default: begin
        dataOut_d = result_q.code;
      end
    endcase
    dataOutEnN_d = pins.outputEnableN; // [RQ16]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_q     <= '0;
      dataOut_q    <= '0;
      dataOutEnN_q <= 1'b1;
      over_q       <= 1'b0;
    end else begin
      result_q     <= result_d;
      dataOut_q    <= dataOut_d;
      dataOutEnN_q <= dataOutEnN_d;
      over_q       <= over_d;
    end
  end

  assign dataOut       = dataOut_q;
  assign dataOutEnN    = dataOutEnN_q;
  assign rangeExceeded = over_q;

endmodule

`default_nettype wire

//--- core/adc_regs_pkg.sv
// Constants, register map and carrier types of the converter register port.
// Assumes one sample clock drives the whole port; no other clock is involved.
// Summary of operation
// [RQ1] Two select bits choose one of four registers.
// [RQ2] Gain, offset and control clear on reset.
// [RQ3] Address zero reads the 14-bit result.
// [RQ4] Result spans full 14-bit signed or unsigned range.
// [RQ5] Control bit eleven picks two's complement coding.
// [RQ6] Gain low three bits set amplifier gain.
// [RQ7] Offset low byte holds signed correction.
// [RQ8] Enabled correction adds offset to every result.
// [RQ9] Control bit seven low enables correction.
// [RQ10] Control bit thirteen set requests power down.
// [RQ11] Control bit twelve set selects external reference.
// [RQ12] Control bits ten to eight select test stimulus.
// [RQ13] Host writes zero into the spare bit.
// [RQ14] Address three reads back the control settings.
// [RQ15] Results reach the pins after the pipeline latency.
// [RQ16] Data pins driven only while output enable low.
// [RQ17] Range flag follows data through same pipeline.
// [RQ18] Write strobe end with select low captures data.
package adc_regs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 14;
  localparam int ADDR_W = 2;
  localparam int GAIN_W = 3;
  localparam int OFFS_W = 8;
  localparam int STIM_W = 3;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_GAIN   = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_SETUP  = 2'h3;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SETUP_SLEEP_BIT  = 13;
  localparam int SETUP_EXTREF_BIT = 12;
  localparam int SETUP_TWOS_BIT   = 11;
  localparam int SETUP_STIM_LSB   = 8;
  localparam int SETUP_OFFDIS_BIT = 7;
  localparam int SETUP_SPARE_BIT  = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] GAIN_RESET   = 14'h0000;
  localparam logic [DATA_W-1:0] OFFSET_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] SETUP_RESET  = 14'h0000;

  // ----------------------------------------------------------------
  // Code limits in two's complement
  // ----------------------------------------------------------------
  localparam logic signed [DATA_W:0] CODE_MAX = 15'h1FFF;
  localparam logic signed [DATA_W:0] CODE_MIN = 15'h6000;

  // ----------------------------------------------------------------
  // Latency: printed in tenths of a cycle, rounded up to whole cycles
  // ----------------------------------------------------------------
  localparam int LATENCY_TENTHS = 95;
  localparam int LATENCY_CYCLES = (LATENCY_TENTHS + 9) / 10;
  localparam int PATH_CYCLES    = 3;
  localparam int PIPE_STAGES    = LATENCY_CYCLES - PATH_CYCLES + 1;

  // ----------------------------------------------------------------
  // Host pin bundle and its idle level
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              chipSelectN;
    logic              writeStrobeN;
    logic              outputEnableN;
    logic              regSelectHi;
    logic              regSelectLo;
    logic [DATA_W-1:0] data;
  } host_pins_s;

  localparam int PINS_W = $bits(host_pins_s);
  localparam logic [PINS_W-1:0] PINS_IDLE = 19'h7_0000;

  // ----------------------------------------------------------------
  // Sample word carried through the pipeline
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic              over;
  } sample_s;

  localparam int SAMPLE_W = $bits(sample_s);

endpackage

//--- core/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W-1:0] rdPtr_d;
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] wrPtr_d;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake and next state
  // ----------------------------------------------------------------
  assign inReady  = (count_q != CNT_W'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    mem_d   = mem_q;
    rdPtr_d = rdPtr_q;
    wrPtr_d = wrPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      count_q <= '0;
      rdPtr_q <= '0;
      wrPtr_q <= '0;
    end else begin
      mem_q   <= mem_d;
      count_q <= count_d;
      rdPtr_q <= rdPtr_d;
      wrPtr_q <= wrPtr_d;
    end
  end

endmodule

`default_nettype wire

//--- dv/adc_port_checker.sv
// Pin-level assertions for the converter register port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module adc_port_checker #(
  parameter int PIPE_STAGES = 8
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        chipSelectN,
  input wire logic        writeStrobeN,
  input wire logic        outputEnableN,
  input wire logic        regSelectHi,
  input wire logic        regSelectLo,
  input wire logic [13:0] dataIn,
  input wire logic [13:0] dataOut,
  input wire logic        dataOutEnN,
  input wire logic [13:0] rawSample,
  input wire logic        rawValid,
  input wire logic        rawOverRange,
  input wire logic        sampleReady,
  input wire logic        rangeExceeded,
  input wire logic        sleepRequest,
  input wire logic        extRefSelect,
  input wire logic [2:0]  gainCode,
  input wire logic [2:0]  stimulusSelect
);
  localparam int LAT = PIPE_STAGES + 3;
  logic       taken;
  logic       quiet;
  logic [5:0] quietCnt_q;
  logic [5:0] quietCnt_d;
  logic [4:0] sleepCnt_q;
  logic [4:0] sleepCnt_d;

  // ------------------------------------------------------------
  // Counters of settled conditions.
  // ------------------------------------------------------------
  always_comb begin
    taken = rawValid && sampleReady && !sleepRequest;
    quiet = quietCnt_q == 6'h3F;
    quietCnt_d = (reset || !chipSelectN) ? 6'h00 : quietCnt_q + 6'(!quiet);
    sleepCnt_d = (reset || !sleepRequest) ? 5'h00 : sleepCnt_q + 5'(sleepCnt_q != 5'h1F);
  end
  always_ff @(posedge clk) begin
    quietCnt_q <= quietCnt_d;
    sleepCnt_q <= sleepCnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_cfg: assert property (
    $fell(reset) |-> gainCode == 3'h0 && stimulusSelect == 3'h0
    && !sleepRequest && !extRefSelect) else $error("setup not cleared by reset");
  a_reset_pins: assert property ($fell(reset) |-> dataOutEnN && !rangeExceeded)
    else $error("pins not idle after reset");
  a_float_idle: assert property (outputEnableN [*7] |-> dataOutEnN)
    else $error("data driven without output enable");
  a_drive_read: assert property (!outputEnableN [*7] |-> !dataOutEnN)
    else $error("data not driven under output enable");
  a_cfg_cs: assert property (
    !$stable({gainCode, stimulusSelect, sleepRequest, extRefSelect}) |-> !$past(chipSelectN, 3))
    else $error("setup changed without chip select");
  a_gain_addr: assert property (
    $changed(gainCode) |-> $past({regSelectHi, regSelectLo}, 3) == 2'h1)
    else $error("gain changed from wrong address");
  a_setup_addr: assert property (
    $changed({stimulusSelect, sleepRequest, extRefSelect})
    |-> $past({regSelectHi, regSelectLo}, 3) == 2'h3)
    else $error("control changed from wrong address");
  a_range_lat: assert property (
    $changed(rangeExceeded) && quiet |-> $past(taken, LAT))
    else $error("range flag off the pipeline latency");
  a_sleep_hold: assert property (
    sleepCnt_q == 5'h1F && quiet |=> $stable(rangeExceeded) && $stable(dataOut))
    else $error("result changed in power down");
  c_stall: cover property (!sampleReady);
  c_range: cover property ($rose(rangeExceeded));
  c_sleep: cover property ($rose(sleepRequest));
endmodule
`default_nettype wire

//--- dv/host_model.sv
// Host processor model on the converter's parallel pins.
// Assumes the bench resolves the shared data bus from both enables.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic        clk,
  input  wire logic [13:0] busData,
  output logic             chipSelectN,
  output logic             writeStrobeN,
  output logic             outputEnableN,
  output logic             regSelectHi,
  output logic             regSelectLo,
  output logic [13:0]      hostData,
  output logic             hostDrive
);
  initial begin
    chipSelectN = 1'b1;
    writeStrobeN = 1'b1;
    outputEnableN = 1'b1;
    {regSelectHi, regSelectLo} = 2'h0;
    hostData = 14'h0000;
    hostDrive = 1'b0;
  end
  task automatic write(input logic [1:0] a, input logic [13:0] v, input logic en);
    @(posedge clk);
    outputEnableN <= 1'b1;
    repeat (6) @(posedge clk);
    chipSelectN <= !en;
    {regSelectHi, regSelectLo} <= a;
    hostData <= v;
    hostDrive <= 1'b1;
    writeStrobeN <= 1'b0;
    repeat (6) @(posedge clk);
    writeStrobeN <= 1'b1;
    repeat (8) @(posedge clk);
    chipSelectN <= 1'b1;
    hostDrive <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic read(input logic [1:0] a, output logic [13:0] v);
    @(posedge clk);
    chipSelectN <= 1'b0;
    {regSelectHi, regSelectLo} <= a;
    outputEnableN <= 1'b0;
    repeat (9) @(posedge clk);
    v = busData;
    outputEnableN <= 1'b1;
    chipSelectN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic idle(input logic oe);
    @(posedge clk);
    chipSelectN <= 1'b1;
    {regSelectHi, regSelectLo} <= 2'h0;
    outputEnableN <= oe;
  endtask
  task automatic freeze();
    @(posedge clk);
    chipSelectN <= 1'b0;
    {regSelectHi, regSelectLo} <= 2'h0;
    outputEnableN <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the converter register port.
// Assumes the host model drives the pins and the bench resolves the bus.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  chipSelectN, writeStrobeN, outputEnableN, regSelectHi, regSelectLo;
  logic                  dataOutEnN, hostDrive, rawValid, rawOverRange, sampleReady;
  logic                  rangeExceeded, sleepRequest, extRefSelect;
  logic                  streamOn = 1'b0;
  logic [2:0]            gainCode, stimulusSelect;
  logic [13:0]           dataIn, dataOut, hostData, rawSample, rdv;
  logic [13:0]           busFloat = 14'h0000;
  logic [10:0]           dl = 11'h000;
  logic [31:0]           rnd = 32'h0000_ECC2;
  logic [13:0]           regs [4] = '{default: 14'h0000};
  logic [13:0]           cfgOff [4] = '{14'h0000, 14'h007F, 14'h0080, 14'h0055};
  logic [13:0]           cfgSet [4] = '{14'h0880, 14'h0800, 14'h0000, 14'h0080};
  int                    fails = 0;
  int                    checkCount = 0;
  int                    k;
  adc_regs_pkg::sample_s q[$];
  adc_regs_pkg::sample_s cur = '0;
  adc_regs_pkg::sample_s lastExp;

  always #5 clk = ~clk;
  assign dataIn = !dataOutEnN ? dataOut : (hostDrive ? hostData : busFloat);
  host_model host (.clk, .busData(dataIn), .chipSelectN, .writeStrobeN, .outputEnableN,
    .regSelectHi, .regSelectLo, .hostData, .hostDrive);
  adc_host_register_port DUT (.clk, .reset, .chipSelectN, .writeStrobeN, .outputEnableN,
    .regSelectHi, .regSelectLo, .dataIn, .dataOut, .dataOutEnN, .rawSample, .rawValid,
    .rawOverRange, .sampleReady, .rangeExceeded, .sleepRequest, .extRefSelect, .gainCode,
    .stimulusSelect);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [13:0] calc(input logic [13:0] raw);
    logic [14:0] s;
    s = {raw[13], raw} + (regs[3][7] ? 15'h0000 : {{7{regs[2][7]}}, regs[2][7:0]});
    if (s[14] != s[13]) s[13:0] = s[14] ? 14'h2000 : 14'h1FFF;
    return s[13:0] ^ {!regs[3][11], 13'h0000};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [13:0] v);
    host.write(a, v, 1'b1);
    if (a != 2'h0) regs[a] = v;
  endtask
  task automatic rd(input logic [1:0] a);
    host.read(a, rdv);
    check("register", 32'(rdv), 32'(regs[a]));
  endtask
  task automatic run(input int n);
    host.idle(1'b0);
    repeat (8) @(posedge clk);
    streamOn = 1'b1;
    repeat (n) begin
      @(posedge clk);
      rnd = xs(rnd);
      rawValid <= rnd[0] | rnd[1];
      rawOverRange <= rnd[2];
      rawSample <= (rnd[6:4] == 3'h0) ? {rnd[7], {13{!rnd[7]}}} : rnd[29:16];
    end
    @(posedge clk);
    rawValid <= 1'b0;
    repeat (16) @(posedge clk);
    streamOn = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Expected results noted at intake, compared at the pins.
  // ------------------------------------------------------------
  always @(posedge clk) begin
    busFloat <= ~busFloat;
    dl <= {dl[9:0], rawValid && sampleReady && !regs[3][13]};
    if (rawValid && sampleReady && !regs[3][13]) begin
      lastExp = '{calc(rawSample), rawOverRange};
      q.push_back(lastExp);
    end
  end
  always @(negedge clk) begin
    if (dl[10]) cur = q.pop_front();
    if (streamOn) begin
      check("result", 32'(dataOut), 32'(cur.code));
      check("range", 32'(rangeExceeded), 32'(cur.over));
    end
  end

  initial begin
    rawSample = 14'h0000;
    rawValid = 1'b0;
    rawOverRange = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int a = 1; a < 4; a++) rd(2'(a));
    rnd = xs(rnd);
    wr(2'h1, rnd[13:0]);
    rd(2'h1);
    check("gain", 32'(gainCode), 32'(regs[1][2:0]));
    wr(2'h2, rnd[27:14]);
    rd(2'h2);
    wr(2'h0, 14'h3FFF);
    host.write(2'h1, ~regs[1], 1'b0);
    rd(2'h1);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      wr(2'h3, {1'b0, rnd[12:11], 3'(i), rnd[7], 1'b0, rnd[5:0]});
      rd(2'h3);
      check("stimulus", 32'(stimulusSelect), i);
      check("reference", 32'(extRefSelect), 32'(regs[3][12]));
    end
    for (int j = 0; j < 4; j++) begin
      wr(2'h2, cfgOff[j]);
      wr(2'h3, cfgSet[j]);
      run(60);
    end
    wr(2'h3, 14'h2000);
    check("sleep", 32'(sleepRequest), 32'h0000_0001);
    run(40);
    wr(2'h3, 14'h0800);
    host.freeze();
    rawValid <= 1'b1;
    k = 0;
    repeat (80) begin
      @(posedge clk);
      rnd = xs(rnd);
      rawSample <= rnd[13:0];
      @(negedge clk);
      if (sampleReady === 1'b0) break;
      k++;
    end
    check("refusal", 32'(k < 80), 32'h0000_0001);
    @(posedge clk);
    rawValid <= 1'b0;
    host.idle(1'b0);
    repeat (40) @(posedge clk);
    @(negedge clk);
    q.delete();
    dl = 11'h000;
    cur = lastExp;
    streamOn = 1'b1;
    repeat (4) @(negedge clk);
    streamOn = 1'b0;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    regs = '{default: 14'h0000};
    rd(2'h1);
    rd(2'h3);
    end_of_test();
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule

bind adc_host_register_port adc_port_checker #(.PIPE_STAGES(PIPE_STAGES)) chk (.clk, .reset,
  .chipSelectN, .writeStrobeN, .outputEnableN, .regSelectHi, .regSelectLo, .dataIn, .dataOut,
  .dataOutEnN, .rawSample, .rawValid, .rawOverRange, .sampleReady, .rangeExceeded,
  .sleepRequest, .extRefSelect, .gainCode, .stimulusSelect);
`default_nettype wire
